// file: serial_unit_pkg.sv
// Purpose: Shared constants and types for the serial unit control block.
// Assumes: 16-bit register port, byte-style addresses in steps of four.
// Notes: Offsets are local to this block's register window.
package serial_unit_pkg;

  // ==========================================================
  // Register port geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;

  // ==========================================================
  // Register offsets
  localparam logic [7:0] ADDR_CLK_ENABLE = 8'h00;
  localparam logic [7:0] ADDR_PRESCALER = 8'h04;
  localparam logic [7:0] ADDR_STOP_TRIG = 8'h08;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_REQ = 8'h10;
  localparam logic [7:0] ADDR_CHAN_CTRL = 8'h14;
  localparam logic [7:0] ADDR_CHAN_STAT = 8'h18;
  localparam logic [7:0] ADDR_EVT_STATUS = 8'h1c;
  localparam logic [7:0] ADDR_EVT_CLEAR = 8'h20;
  localparam logic [7:0] ADDR_EVT_ENABLE = 8'h24;

  // ==========================================================
  // Field positions
  localparam int GATE_BIT = 2;
  localparam int PRESC_FIRST_LSB = 0;
  localparam int PRESC_SECOND_LSB = 4;
  localparam int PRESC_W = 4;
  localparam int STOP_BIT = 0;
  localparam int CH_IRQ_BIT = 5;
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_SRC_BIT = 1;
  localparam int EVT_CHAN_IRQ = 0;
  localparam int EVT_STOPPED = 1;
  localparam int EVT_W = 2;
  localparam int DIV_W = 15;

  // ==========================================================
  // Reset values and fixed read bits
  localparam logic [7:0] CLK_ENABLE_RESET = 8'h00;
  localparam logic [7:0] IRQ_MASK_RESET = 8'hff;
  localparam logic [7:0] IRQ_REQ_RESET = 8'h00;
  localparam logic [7:0] MASK_FIXED_ONES = 8'h18;
  localparam logic [7:0] REQ_KEEP = 8'he7;
  localparam logic [3:0] PRESC_RESET = 4'h0;
  localparam logic [DATA_W-1:0] READ_ZERO = 16'h0000;

  // Low-bit mask that decides a divide-by-2^sel tick
  function automatic logic [DIV_W-1:0] div_mask(input logic [3:0] sel);
    logic [15:0] m;
    m = (16'h0001 << sel) - 16'h0001;
    return m[DIV_W-1:0];
  endfunction

endpackage

// file: prescale_if.sv
// Purpose: Carries prescaler selects and operation clock ticks.
// Assumes: One clock domain shared by both ends.
// Notes: Ticks are one-cycle enable pulses.
`timescale 1ns/1ps
interface prescale_if;
  logic run;
  logic [3:0] selFirst;
  logic [3:0] selSecond;
  logic tickFirst;
  logic tickSecond;
  modport ctrl(output run, output selFirst, output selSecond, input tickFirst, input tickSecond);
  modport div(input run, input selFirst, input selSecond, output tickFirst, output tickSecond);
endinterface

// file: prescale_divider.sv
// Purpose: Free-running divider giving two power-of-two tick enables.
// Assumes: run low holds the counter cleared.
// Notes: Ticks fall where the low sel bits of the count are all ones.
`timescale 1ns/1ps
module prescale_divider
  import serial_unit_pkg::*;
(
  input wire logic ref_clk, // System clock
  input wire logic nrst, // Sync reset, active low
  prescale_if.div pif // Selects in, ticks out
);

  typedef struct packed {
    logic [DIV_W-1:0] cnt;
  } div_state_type;

  div_state_type st_reg;
  div_state_type st_next;

  // ==========================================================
  // Counter; cleared while the unit is held so ticks restart aligned
  always_comb begin
    st_next = st_reg;
    if (!pif.run) begin
      st_next.cnt = '0;
    end else begin
      st_next.cnt = st_reg.cnt + {{(DIV_W-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Shared mask function keeps both selects identical in scheme
  assign pif.tickFirst = pif.run && ((st_reg.cnt & div_mask(pif.selFirst)) == div_mask(pif.selFirst));
  assign pif.tickSecond = pif.run && ((st_reg.cnt & div_mask(pif.selSecond)) == div_mask(pif.selSecond));

endmodule

// file: serial_unit_ctrl.sv
// Purpose: Clock gate, prescaler, channel stop and interrupt flags of a serial unit.
// Assumes: Register port with read data one cycle after the read strobe.
// Notes: Shift engine lives outside and reports transfer-end and buffer-empty pulses.
//
// Chosen here: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps

// Overview of operation
// - With the clock gate bit at 0 the unit gets no clock, sits in reset and ignores writes to its registers.
// - With the clock gate bit at 1 the unit is clocked and its registers can be read and written.
// - The first operation clock is the system clock divided by two to the power of the low prescaler field.
// - Writing 1 to the channel zero stop trigger clears its enable status and stops it; writing 0 does nothing.
// - The channel zero interrupt mask bit at 1 blocks the interrupt and at 0 lets it through.
// - The channel zero request flag reads 1 while a request is pending and software clears it by writing 0.
// - The source select picks transfer-end when 0 and buffer-empty when 1.
module serial_unit_ctrl
  import serial_unit_pkg::*;
(
  input wire logic ref_clk, // System clock, 125 MHz
  input wire logic nrst, // Sync reset, active low
  input wire logic [ADDR_W-1:0] regAddr, // Register address
  input wire logic [DATA_W-1:0] regWdata, // Write data
  input wire logic regWr, // Write strobe
  input wire logic regRd, // Read strobe
  output logic [DATA_W-1:0] regRdata, // Read data, cycle after strobe
  input wire logic transferEnd, // Shift engine transfer-end pulse
  input wire logic bufferEmpty, // Shift engine buffer-empty pulse
  output logic unitClockEn, // Unit input clock enable
  output logic unitResetN, // Unit reset, active low
  output logic firstOpClkEn, // First operation clock tick
  output logic secondOpClkEn, // Second operation clock tick
  output logic chanEnable, // Channel zero enable status
  output logic chanIrqReq, // Unmasked channel zero request
  output logic irq // Block interrupt, level
);

  typedef struct packed {
    logic [7:0] clkEnable;
    logic [3:0] prescFirst;
    logic [3:0] prescSecond;
    logic chanEn;
    logic srcSel;
    logic [7:0] irqMask;
    logic [7:0] irqReq;
    logic [EVT_W-1:0] evtStatus;
    logic [EVT_W-1:0] evtEnable;
    logic [DATA_W-1:0] rdata;
  } ctrl_state_type;

  localparam ctrl_state_type STATE_RESET = '{
    clkEnable: CLK_ENABLE_RESET,
    prescFirst: PRESC_RESET,
    prescSecond: PRESC_RESET,
    chanEn: 1'b0,
    srcSel: 1'b0,
    irqMask: IRQ_MASK_RESET,
    irqReq: IRQ_REQ_RESET,
    evtStatus: '0,
    evtEnable: '0,
    rdata: READ_ZERO
  };

  ctrl_state_type st_reg;
  ctrl_state_type st_next;

  logic gateOn;
  logic wrPresc;
  logic wrStop;
  logic wrCtrl;
  logic wrIrqReq;
  logic chanEvt;
  logic stopEvt;
  logic [EVT_W-1:0] evtSet;
  logic [DATA_W-1:0] rdMux;
  logic [7:0] prescView;

  prescale_if pif();

  // ==========================================================
  // Operation clock divider
  prescale_divider u_div (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .pif(pif.div)
  );

  // Divider only runs while the unit is clocked
  assign pif.run = gateOn;
  assign pif.selFirst = st_reg.prescFirst;
  assign pif.selSecond = st_reg.prescSecond;

  // ==========================================================
  // Decode and events
  assign gateOn = st_reg.clkEnable[GATE_BIT];
  // Unit registers only take writes while the gate is open
  assign wrPresc = regWr && gateOn && (regAddr == ADDR_PRESCALER);
  assign wrStop = regWr && gateOn && (regAddr == ADDR_STOP_TRIG);
  assign wrCtrl = regWr && gateOn && (regAddr == ADDR_CHAN_CTRL);
  assign wrIrqReq = regWr && (regAddr == ADDR_IRQ_REQ);
  // Selected source raises the channel request
  assign chanEvt = gateOn && st_reg.chanEn && (st_reg.srcSel ? bufferEmpty : transferEnd);
  assign stopEvt = wrStop && regWdata[STOP_BIT] && st_reg.chanEn;
  assign prescView = {st_reg.prescSecond, st_reg.prescFirst};

  always_comb begin
    evtSet = '0;
    evtSet[EVT_CHAN_IRQ] = chanEvt;
    evtSet[EVT_STOPPED] = stopEvt;
  end

  // ==========================================================
  // Read multiplexer; gated unit registers read as zero
  always_comb begin
    rdMux = READ_ZERO;
    case (regAddr)
      ADDR_CLK_ENABLE: begin
        rdMux[7:0] = st_reg.clkEnable;
      end
      ADDR_PRESCALER: begin
        if (gateOn) begin
          rdMux[7:0] = prescView;
        end
      end
      ADDR_IRQ_MASK: begin
        rdMux[7:0] = st_reg.irqMask | MASK_FIXED_ONES;
      end
      ADDR_IRQ_REQ: begin
        rdMux[7:0] = st_reg.irqReq & REQ_KEEP;
      end
      ADDR_CHAN_CTRL: begin
        if (gateOn) begin
          rdMux[CTRL_SRC_BIT] = st_reg.srcSel;
        end
      end
      ADDR_CHAN_STAT: begin
        rdMux[0] = st_reg.chanEn;
      end
      ADDR_EVT_STATUS: begin
        rdMux[EVT_W-1:0] = st_reg.evtStatus;
      end
      ADDR_EVT_ENABLE: begin
        rdMux[EVT_W-1:0] = st_reg.evtEnable;
      end
      default: begin
        rdMux = READ_ZERO;
      end
    endcase
  end

  // ==========================================================
  // Next state
  always_comb begin
    st_next = st_reg;
    st_next.rdata = regRd ? rdMux : READ_ZERO;
    if (regWr && (regAddr == ADDR_CLK_ENABLE)) begin
      st_next.clkEnable = regWdata[7:0];
    end
    if (wrPresc) begin
      st_next.prescFirst = regWdata[PRESC_FIRST_LSB +: PRESC_W];
      st_next.prescSecond = regWdata[PRESC_SECOND_LSB +: PRESC_W];
    end
    if (wrCtrl) begin
      st_next.srcSel = regWdata[CTRL_SRC_BIT];
      if (regWdata[CTRL_START_BIT]) begin
        st_next.chanEn = 1'b1;
      end
    end
    // Stop trigger 1 clears enable; a 0 leaves it alone
    if (wrStop && regWdata[STOP_BIT]) begin
      st_next.chanEn = 1'b0;
    end
    if (regWr && (regAddr == ADDR_IRQ_MASK)) begin
      st_next.irqMask = regWdata[7:0];
    end
    // Hardware set wins over a software clear in the same cycle
    if (wrIrqReq) begin
      st_next.irqReq = regWdata[7:0] & REQ_KEEP;
    end
    if (chanEvt) begin
      st_next.irqReq[CH_IRQ_BIT] = 1'b1;
    end
    if (regWr && (regAddr == ADDR_EVT_ENABLE)) begin
      st_next.evtEnable = regWdata[EVT_W-1:0];
    end
    if (regWr && (regAddr == ADDR_EVT_CLEAR)) begin
      st_next.evtStatus = st_reg.evtStatus & ~regWdata[EVT_W-1:0];
    end
    st_next.evtStatus = st_next.evtStatus | evtSet;
    // Closed gate holds the unit in reset; keyed on the gate's next value
    // so that no unit state survives into the first cycle with the gate at 0
    if (!st_next.clkEnable[GATE_BIT]) begin
      st_next.prescFirst = PRESC_RESET;
      st_next.prescSecond = PRESC_RESET;
      st_next.chanEn = 1'b0;
      st_next.srcSel = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      st_reg <= STATE_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // ==========================================================
  // Outputs
  assign regRdata = st_reg.rdata;
  assign unitClockEn = gateOn;
  assign unitResetN = gateOn;
  assign firstOpClkEn = pif.tickFirst;
  assign secondOpClkEn = pif.tickSecond;
  assign chanEnable = st_reg.chanEn;
  // Mask only blocks servicing; the flag itself stays visible
  assign chanIrqReq = st_reg.irqReq[CH_IRQ_BIT] && !st_reg.irqMask[CH_IRQ_BIT];
  assign irq = |(st_reg.evtStatus & st_reg.evtEnable);

  // ==========================================================
  // Assertions
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  property p_gatedReset;
    !gateOn |-> (!unitResetN && !unitClockEn && !firstOpClkEn && !chanEnable);
  endproperty
  a_gatedReset: assert property (p_gatedReset) else $error("unit not held while gate closed");

  property p_writeIgnored;
    (!gateOn && regWr && regAddr == ADDR_PRESCALER) |=> $stable(prescView);
  endproperty
  a_writeIgnored: assert property (p_writeIgnored) else $error("gated prescaler write took effect");

  property p_readBack;
    (gateOn && regRd && regAddr == ADDR_PRESCALER) |=> regRdata[7:0] == $past(prescView);
  endproperty
  a_readBack: assert property (p_readBack) else $error("prescaler read back wrong");

  property p_firstUndivided;
    (gateOn && st_reg.prescFirst == 4'h0) |-> firstOpClkEn;
  endproperty
  a_firstUndivided: assert property (p_firstUndivided) else $error("undivided first clock missed");

  property p_firstHalf;
    (firstOpClkEn && st_reg.prescFirst == 4'h1) ##1 (gateOn && st_reg.prescFirst == 4'h1) |-> !firstOpClkEn;
  endproperty
  a_firstHalf: assert property (p_firstHalf) else $error("divide by two ticked twice");

  property p_secondUndivided;
    (gateOn && st_reg.prescSecond == 4'h0) |-> secondOpClkEn;
  endproperty
  a_secondUndivided: assert property (p_secondUndivided) else $error("undivided second clock missed");

  property p_stopClears;
    (chanEnable && wrStop && regWdata[STOP_BIT]) |=> !chanEnable;
  endproperty
  a_stopClears: assert property (p_stopClears) else $error("stop trigger did not clear enable");

  property p_stopZero;
    (chanEnable && wrStop && !regWdata[STOP_BIT]) |=> chanEnable;
  endproperty
  a_stopZero: assert property (p_stopZero) else $error("stop write of zero changed enable");

  property p_maskBlocks;
    st_reg.irqMask[CH_IRQ_BIT] |-> !chanIrqReq;
  endproperty
  a_maskBlocks: assert property (p_maskBlocks) else $error("masked request reached output");

  property p_flagSet;
    (chanEnable && gateOn && !st_reg.srcSel && transferEnd)
      |=> (st_reg.irqReq[CH_IRQ_BIT] && st_reg.evtStatus[EVT_CHAN_IRQ] && (irq || !st_reg.evtEnable[EVT_CHAN_IRQ]));
  endproperty
  a_flagSet: assert property (p_flagSet) else $error("transfer end did not raise flag");

  property p_flagClear;
    (wrIrqReq && !regWdata[CH_IRQ_BIT] && !chanEvt) |=> !st_reg.irqReq[CH_IRQ_BIT];
  endproperty
  a_flagClear: assert property (p_flagClear) else $error("writing zero did not clear flag");

  property p_srcSelect;
    (st_reg.srcSel && transferEnd && !bufferEmpty && !st_reg.irqReq[CH_IRQ_BIT] && !wrIrqReq)
      |=> !st_reg.irqReq[CH_IRQ_BIT];
  endproperty
  a_srcSelect: assert property (p_srcSelect) else $error("transfer end raised flag in buffer mode");

  // Gate, access, divider, stop, mask, source and flag retention checks
  property p_gateCloseClears;
    (gateOn && regWr && regAddr == ADDR_CLK_ENABLE && !regWdata[GATE_BIT])
      |=> (!chanEnable && !st_reg.srcSel && st_reg.prescFirst == PRESC_RESET && st_reg.prescSecond == PRESC_RESET);
  endproperty
  a_gateCloseClears: assert property (p_gateCloseClears) else $error("closing gate left unit state");

  property p_gatedStartIgnored;
    (!gateOn && regWr && regAddr == ADDR_CHAN_CTRL) |=> !chanEnable;
  endproperty
  a_gatedStartIgnored: assert property (p_gatedStartIgnored) else $error("gated start write took effect");

  property p_gatedReadZero;
    (!gateOn && regRd && regAddr == ADDR_PRESCALER) |=> regRdata == READ_ZERO;
  endproperty
  a_gatedReadZero: assert property (p_gatedReadZero) else $error("gated prescaler read not zero");

  property p_gatedSecondQuiet;
    !gateOn |-> !secondOpClkEn;
  endproperty
  a_gatedSecondQuiet: assert property (p_gatedSecondQuiet) else $error("second clock ticked while gated");

  property p_gateOpen;
    gateOn |-> (unitClockEn && unitResetN);
  endproperty
  a_gateOpen: assert property (p_gateOpen) else $error("open gate did not release unit");

  property p_rdataOneCycle;
    !regRd |=> regRdata == READ_ZERO;
  endproperty
  a_rdataOneCycle: assert property (p_rdataOneCycle) else $error("read data stood without a read");

  property p_secondHalf;
    (secondOpClkEn && st_reg.prescSecond == 4'h1) ##1 (gateOn && st_reg.prescSecond == 4'h1) |-> !secondOpClkEn;
  endproperty
  a_secondHalf: assert property (p_secondHalf) else $error("second divide by two ticked twice");

  property p_stopEvent;
    (chanEnable && wrStop && regWdata[STOP_BIT]) |=> st_reg.evtStatus[EVT_STOPPED];
  endproperty
  a_stopEvent: assert property (p_stopEvent) else $error("stop of running channel not recorded");

  property p_maskPasses;
    (st_reg.irqReq[CH_IRQ_BIT] && !st_reg.irqMask[CH_IRQ_BIT]) |-> chanIrqReq;
  endproperty
  a_maskPasses: assert property (p_maskPasses) else $error("unmasked request not passed");

  property p_flagHeld;
    (st_reg.irqReq[CH_IRQ_BIT] && !(wrIrqReq && !regWdata[CH_IRQ_BIT])) |=> st_reg.irqReq[CH_IRQ_BIT];
  endproperty
  a_flagHeld: assert property (p_flagHeld) else $error("pending flag dropped without clear");

  property p_bufferSets;
    (chanEnable && gateOn && st_reg.srcSel && bufferEmpty) |=> st_reg.irqReq[CH_IRQ_BIT];
  endproperty
  a_bufferSets: assert property (p_bufferSets) else $error("buffer empty did not raise flag");

  property p_srcTransfer;
    (!st_reg.srcSel && bufferEmpty && !transferEnd && !st_reg.irqReq[CH_IRQ_BIT] && !wrIrqReq)
      |=> !st_reg.irqReq[CH_IRQ_BIT];
  endproperty
  a_srcTransfer: assert property (p_srcTransfer) else $error("buffer empty raised flag in transfer mode");

  // Main scenarios the bench is expected to reach
  c_stopRunning: cover property (chanEnable ##1 !chanEnable);
  c_bufferIrq: cover property (st_reg.srcSel && bufferEmpty && chanEnable ##1 chanIrqReq);
  c_slowTick: cover property (gateOn && st_reg.prescFirst == 4'h3 && firstOpClkEn);
  c_blockIrq: cover property (irq);

endmodule

// file: tb_serial_unit_ctrl.sv
// Purpose: Self-checking bench for the serial unit control block.
// Assumes: Register port with read data one cycle after the read strobe.
// Notes: Design-side assertions live in the design files; this bench drives all ports itself.
`timescale 1ns/1ps
module tb_serial_unit_ctrl;
  import serial_unit_pkg::*;

  // ==========================================================
  // Signals
  logic ref_clk, nrst, regWr, regRd, transferEnd, bufferEmpty;
  logic [ADDR_W-1:0] regAddr;
  logic [DATA_W-1:0] regWdata, regRdata;
  logic unitClockEn, unitResetN, firstOpClkEn, secondOpClkEn, chanEnable, chanIrqReq, irq;
  int errTotal = 0;
  int testsRun = 0;
  int n;

  serial_unit_ctrl DUT (
    .ref_clk(ref_clk), .nrst(nrst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata), .transferEnd(transferEnd), .bufferEmpty(bufferEmpty),
    .unitClockEn(unitClockEn), .unitResetN(unitResetN), .firstOpClkEn(firstOpClkEn),
    .secondOpClkEn(secondOpClkEn), .chanEnable(chanEnable), .chanIrqReq(chanIrqReq), .irq(irq)
  );

  // 125 MHz system clock
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  // ==========================================================
  // Tasks
  task automatic testDone();
    if (errTotal == 0 && testsRun > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    testsRun++;
    if (seen !== exp) begin
      errTotal++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One-cycle write strobe, released at the edge that takes it
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge ref_clk);
    regWr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe, so sample mid-cycle there
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge ref_clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge ref_clk);
    regRd <= 1'b0;
    @(negedge ref_clk);
    chk(regRdata, e);
  endtask

  // Packed view: gate, unit reset release, channel enable, channel request, irq
  task automatic outs(input logic [4:0] e);
    @(negedge ref_clk);
    chk({11'h000, unitClockEn, unitResetN, chanEnable, chanIrqReq, irq}, {11'h000, e});
  endtask

  // One-cycle event from the shift engine side
  task automatic pulse(input logic bufEvt);
    @(posedge ref_clk);
    transferEnd <= ~bufEvt;
    bufferEmpty <= bufEvt;
    @(posedge ref_clk);
    transferEnd <= 1'b0;
    bufferEmpty <= 1'b0;
  endtask

  // Cycles between two ticks; bounded so a dead divider cannot hang the run
  task automatic period(input logic sec, input int exp);
    int i;
    int p;
    i = 0;
    p = 0;
    do begin
      @(negedge ref_clk);
      i++;
    end while (((sec ? secondOpClkEn : firstOpClkEn) !== 1'b1) && i < 40000);
    do begin
      @(negedge ref_clk);
      p++;
    end while (((sec ? secondOpClkEn : firstOpClkEn) !== 1'b1) && p < 40000);
    if (i >= 40000 || p >= 40000) begin
      errTotal++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, p, exp);
      testDone();
    end else begin
      chk(p[15:0], exp[15:0]);
    end
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    nrst = 1'b0;
    regWr = 1'b0;
    regRd = 1'b0;
    regAddr = '0;
    regWdata = '0;
    transferEnd = 1'b0;
    bufferEmpty = 1'b0;
    repeat (3) @(posedge ref_clk);
    nrst <= 1'b1;
    outs(5'b00000);
    rd(ADDR_CLK_ENABLE, 16'h0000);
    rd(ADDR_IRQ_MASK, 16'h00ff);
    rd(ADDR_IRQ_REQ, 16'h0000);
    // Gated unit: its registers ignore writes, events are not seen
    wr(ADDR_PRESCALER, 16'h0012);
    rd(ADDR_PRESCALER, 16'h0000);
    wr(ADDR_CHAN_CTRL, 16'h0001);
    outs(5'b00000);
    wr(ADDR_IRQ_MASK, 16'h00df);
    wr(ADDR_EVT_ENABLE, 16'h0003);
    pulse(1'b0);
    rd(ADDR_IRQ_REQ, 16'h0000);
    // Open the gate
    wr(ADDR_CLK_ENABLE, 16'h0004);
    outs(5'b11000);
    rd(ADDR_CLK_ENABLE, 16'h0004);
    wr(ADDR_PRESCALER, 16'h0021);
    rd(ADDR_PRESCALER, 16'h0021);
    @(negedge ref_clk);
    chk(regRdata, 16'h0000);
    // Both dividers, crossing selects, then the largest ratio
    for (n = 0; n < 5; n++) begin
      wr(ADDR_PRESCALER, {8'h00, 4'(4 - n), 4'(n)});
      period(1'b0, 1 << n);
      period(1'b1, 1 << (4 - n));
    end
    wr(ADDR_PRESCALER, 16'h000f);
    period(1'b0, 32768);
    // Stop trigger: zero is no trigger, one stops the channel
    wr(ADDR_CHAN_CTRL, 16'h0001);
    outs(5'b11100);
    wr(ADDR_STOP_TRIG, 16'h0000);
    outs(5'b11100);
    wr(ADDR_STOP_TRIG, 16'h0001);
    outs(5'b11001);
    rd(ADDR_EVT_STATUS, 16'h0002);
    wr(ADDR_EVT_CLEAR, 16'h0002);
    outs(5'b11000);
    // Transfer-end source: buffer-empty must not raise the flag
    wr(ADDR_CHAN_CTRL, 16'h0001);
    pulse(1'b1);
    rd(ADDR_IRQ_REQ, 16'h0000);
    pulse(1'b0);
    outs(5'b11111);
    rd(ADDR_IRQ_REQ, 16'h0020);
    rd(ADDR_EVT_STATUS, 16'h0001);
    wr(ADDR_IRQ_MASK, 16'h00ff);
    outs(5'b11101);
    wr(ADDR_EVT_ENABLE, 16'h0000);
    outs(5'b11100);
    wr(ADDR_EVT_CLEAR, 16'h0001);
    wr(ADDR_EVT_ENABLE, 16'h0003);
    rd(ADDR_EVT_STATUS, 16'h0000);
    wr(ADDR_IRQ_REQ, 16'h0000);
    rd(ADDR_IRQ_REQ, 16'h0000);
    // Buffer-empty source: transfer-end must not raise the flag
    wr(ADDR_IRQ_MASK, 16'h00df);
    wr(ADDR_CHAN_CTRL, 16'h0002);
    pulse(1'b0);
    rd(ADDR_IRQ_REQ, 16'h0000);
    pulse(1'b1);
    outs(5'b11111);
    // Unmapped and write-only places read zero
    wr(8'h30, 16'hffff);
    rd(8'h30, 16'h0000);
    rd(ADDR_STOP_TRIG, 16'h0000);
    rd(ADDR_EVT_CLEAR, 16'h0000);
    // Closing the gate resets the unit; flags outside it survive
    wr(ADDR_CLK_ENABLE, 16'h0000);
    outs(5'b00011);
    rd(ADDR_PRESCALER, 16'h0000);
    wr(ADDR_CLK_ENABLE, 16'h0004);
    rd(ADDR_PRESCALER, 16'h0000);
    testDone();
  end
endmodule
